// file: hdl/ewf_pkg.sv
// shared constants and types of the extended weight frame transmitter
package ewf_pkg;

  // character codes
  localparam logic [6:0] EWF_SOH      = 7'h01;
  localparam logic [6:0] EWF_CR       = 7'h0d;
  localparam logic [6:0] EWF_SP       = 7'h20;
  localparam logic [6:0] EWF_MINUS    = 7'h2d;
  localparam logic [6:0] EWF_DOT      = 7'h2e;
  localparam logic [6:0] EWF_ZERO     = 7'h30;
  localparam logic [6:0] EWF_ADR_DEF  = 7'h31;
  localparam logic [6:0] EWF_ERR_E    = 7'h45;
  localparam logic [6:0] EWF_SRC_SCL  = 7'h41;
  localparam logic [6:0] EWF_SRC_OTH  = 7'h55;
  localparam logic [6:0] EWF_HEX_A    = 7'h61;
  localparam logic [6:0] EWF_ONE_BIT  = 7'h20;
  localparam logic [3:0] EWF_ADR_MIN  = 4'h1;
  localparam logic [3:0] EWF_ADR_MAX  = 4'h9;
  localparam logic [3:0] EWF_UNIT_MAX = 4'h9;
  localparam logic [3:0] EWF_UNIT_NONE = 4'h0;
  localparam logic [3:0] EWF_HEX_TEN  = 4'ha;

  // character positions within one frame
  localparam int          EWF_FRAME_LEN = 24;
  localparam logic [4:0]  EWF_IDX_SOH   = 5'h00;
  localparam logic [4:0]  EWF_IDX_ADR   = 5'h01;
  localparam logic [4:0]  EWF_IDX_SB1   = 5'h02;
  localparam logic [4:0]  EWF_IDX_SB3   = 5'h04;
  localparam logic [4:0]  EWF_IDX_SB4   = 5'h05;
  localparam int          EWF_IDX_W     = 6;
  localparam int          EWF_W_LEN     = 9;
  localparam int          EWF_IDX_T     = 15;
  localparam int          EWF_T_LEN     = 8;
  localparam logic [4:0]  EWF_IDX_CR    = 5'h17;
  localparam logic [4:0]  EWF_IDX_CKS   = 5'h18;

  // status byte three field positions
  localparam int EWF_SB3_INVALID = 0;
  localparam int EWF_SB3_UNDER   = 1;
  localparam int EWF_SB3_OVER    = 2;

  typedef enum logic [1:0] {EWF_PAR_NONE, EWF_PAR_EVEN, EWF_PAR_ODD} ewf_par_t;

  // per-scale snapshot offered to the framer
  typedef struct packed {
    logic [3:0]  addr_sel;
    logic [3:0]  unit;
    logic        center_zero;
    logic        motion;
    logic        net_mode;
    logic [1:0]  tare_type;
    logic [1:0]  range;
    logic        expand_ten;
    logic        invalid;
    logic        under_zero;
    logic        over_cap;
    logic        power_up;
    logic        print_init;
    logic        below_min;
    logic [5:0]  app_flags;
    logic        negative;
    logic [31:0] wt_digits;
    logic [2:0]  wt_dp;
    logic [31:0] tare_digits;
    logic [2:0]  tare_dp;
    logic        err_en;
    logic        err_other;
    logic [7:0]  err_code;
  } ewf_scale_t;

endpackage

// file: hdl/ewf_tx.sv
// extended continuous weight frame builder and character streamer
//
// Contract
// - frame order: soh, address, status, weight, tare, cr
// - first character is start-of-header 01h
// - address 31h..39h, default 31h
// - one full frame per enabled scale
// - nine-char weight, leading zeros become spaces
// - minus sign right before leading digit
// - eight-char tare, leading zeros become spaces
// - checksum is negated seven-bit sum
// - checksum uses same parity as others
// - status one low nibble carries unit code
// - status one: zero center, motion, bit5 set
// - status two: net, tare type, range, expand
// - status three: invalid, under, over, powerup, print
// - status four: six app flags, bit5 set
// - invalid set on over, under or doubt
// - error record may replace weight field
// - error code matches logged condition code
module ewf_tx
  import ewf_pkg::*;
#(
  parameter int NSC = 4
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // configuration
  input  wire logic                 out_en,
  input  wire logic                 cks_en,
  input  wire ewf_par_t             par_mode,
  input  wire logic [NSC-1:0]       scale_en,
  input  wire ewf_scale_t [NSC-1:0] scale_i,
  // character stream to the line driver
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output logic [7:0]                tx_char,
  output logic                      tx_last,
  output logic [$clog2(NSC)-1:0]    tx_scale
);

  localparam int SW = $clog2(NSC);

  typedef enum {S_IDLE, S_SEND} ewf_st_t;

  ////////////////////////////////////////////////////////////////////////
  // field formatting

  // right-justified digit field with blanking; a full field leaves no room
  // for the sign, so callers must keep one leading position free
  function automatic logic [8:0][6:0] fmt_field(input logic [31:0] dig,
                                                input logic [2:0]  dp,
                                                input logic        neg);
    logic [8:0][6:0] r;
    logic [8:0]      keep;
    logic            seen;
    logic [3:0]      d;
    logic            is_dot;
    int              unit_pos;
    r        = '0;
    keep     = '0;
    seen     = 1'b0;
    d        = 4'h0;
    is_dot   = 1'b0;
    unit_pos = (dp == 3'h0) ? 0 : int'(dp) + 1;
    for (int p = 8; p >= 0; p--) begin
      is_dot = (dp != 3'h0) && (p == int'(dp));
      if (dp == 3'h0) begin
        d = (p < 8) ? dig[p*4 +: 4] : 4'h0;
      end else if (p < int'(dp)) begin
        d = dig[p*4 +: 4];
      end else if (is_dot) begin
        d = 4'h0;
      end else begin
        d = dig[(p-1)*4 +: 4];
      end
      seen    = seen | (d != 4'h0) | (p <= unit_pos);
      keep[p] = seen;
      r[p]    = !seen ? EWF_SP : is_dot ? EWF_DOT : (EWF_ZERO | {3'h0, d});
    end
    for (int p = 8; p >= 1; p--) begin
      if (neg && !keep[p] && keep[p-1]) begin
        r[p] = EWF_MINUS;
      end
    end
    return r;
  endfunction

  function automatic logic [6:0] hex_char(input logic [3:0] n);
    return (n < EWF_HEX_TEN) ? (EWF_ZERO | {3'h0, n})
                             : 7'(EWF_HEX_A + {3'h0, n - EWF_HEX_TEN});
  endfunction

  function automatic logic [7:0] add_parity(input logic [6:0] c, input ewf_par_t m);
    logic pb;
    pb = (m == EWF_PAR_EVEN) ? ^c : (m == EWF_PAR_ODD) ? ~^c : 1'b0;
    return {pb, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // scale selection

  logic [SW-1:0] cur_q;
  logic [SW-1:0] nxt_scale;
  logic          any_en;

  // round robin from the scale after the last one sent
  always_comb begin
    logic found;
    found     = 1'b0;
    nxt_scale = cur_q;
    for (int k = 1; k <= NSC; k++) begin
      if (!found && scale_en[(int'(cur_q) + k) % NSC]) begin
        found     = 1'b1;
        nxt_scale = SW'((int'(cur_q) + k) % NSC);
      end
    end
  end

  assign any_en = |scale_en;

  ////////////////////////////////////////////////////////////////////////
  // frame image of the selected scale

  ewf_scale_t                        sel;
  logic [EWF_FRAME_LEN-1:0][6:0]     frame_d;
  logic [8:0][6:0]                   wt_fld;
  logic [8:0][6:0]                   tare_fld;
  logic [8:0][6:0]                   err_fld;
  logic [6:0]                        adr_ch;
  logic [3:0]                        unit_ok;
  logic                              invalid_f;

  assign sel       = scale_i[nxt_scale];
  assign adr_ch    = (sel.addr_sel >= EWF_ADR_MIN && sel.addr_sel <= EWF_ADR_MAX)
                     ? (EWF_ZERO | {3'h0, sel.addr_sel}) : EWF_ADR_DEF;
  assign unit_ok   = (sel.unit <= EWF_UNIT_MAX) ? sel.unit : EWF_UNIT_NONE;
  assign invalid_f = sel.invalid | sel.over_cap | sel.under_zero;
  assign wt_fld    = fmt_field(sel.wt_digits, sel.wt_dp, sel.negative);
  assign tare_fld  = fmt_field(sel.tare_digits, sel.tare_dp, 1'b0);
  assign err_fld   = {EWF_ERR_E, sel.err_other ? EWF_SRC_OTH : EWF_SRC_SCL,
                      EWF_ZERO, EWF_ZERO, EWF_ZERO,
                      hex_char(sel.err_code[7:4]), hex_char(sel.err_code[3:0]),
                      EWF_SP, EWF_SP};

  always_comb begin
    frame_d                 = '0;
    frame_d[EWF_IDX_SOH]    = EWF_SOH;
    frame_d[EWF_IDX_ADR]    = adr_ch;
    frame_d[EWF_IDX_SB1]    = EWF_ONE_BIT | {sel.motion, 1'b0, sel.center_zero, unit_ok};
    frame_d[EWF_IDX_SB1+1]  = EWF_ONE_BIT | {sel.expand_ten, 1'b0, sel.range,
                                             sel.tare_type, sel.net_mode};
    frame_d[EWF_IDX_SB3]    = EWF_ONE_BIT | {sel.below_min, 1'b0, sel.print_init,
                                             sel.power_up, sel.over_cap, sel.under_zero,
                                             invalid_f};
    frame_d[EWF_IDX_SB4]    = EWF_ONE_BIT | {sel.app_flags[5], 1'b0, sel.app_flags[4:0]};
    for (int i = 0; i < EWF_W_LEN; i++) begin
      frame_d[EWF_IDX_W+i]  = (sel.err_en ? err_fld[8-i] : wt_fld[8-i]);
    end
    for (int i = 0; i < EWF_T_LEN; i++) begin
      frame_d[EWF_IDX_T+i]  = tare_fld[7-i];
    end
    frame_d[EWF_IDX_CR]     = EWF_CR;
  end

  ////////////////////////////////////////////////////////////////////////
  // streaming

  ewf_st_t                       st_q;
  logic [4:0]                    idx_q;
  logic [6:0]                    sum_q;
  logic                          cks_q;
  ewf_par_t                      par_q;
  logic [EWF_FRAME_LEN-1:0][6:0] frame_q;
  logic [7:0]                    char_q;
  logic                          start;
  logic                          take;
  logic [6:0]                    sum_nx;
  logic [4:0]                    idx_nx;
  logic [6:0]                    nxt_ch;
  logic                          at_cr;
  logic                          at_end;

  assign start  = (st_q == S_IDLE) && out_en && any_en;
  assign take   = (st_q == S_SEND) && tx_ready;
  assign sum_nx = 7'(sum_q + char_q[6:0]);
  assign at_cr  = (idx_q == EWF_IDX_CR);
  assign at_end = (at_cr && !cks_q) || (idx_q == EWF_IDX_CKS);
  assign idx_nx = 5'(idx_q + 5'h01);
  assign nxt_ch = at_cr ? 7'(7'h00 - sum_nx) : frame_q[idx_nx];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= S_IDLE;
      idx_q   <= '0;
      sum_q   <= '0;
      cks_q   <= 1'b0;
      par_q   <= EWF_PAR_NONE;
      cur_q   <= '0;
      frame_q <= '0;
      char_q  <= '0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (start) begin
            st_q    <= S_SEND;
            frame_q <= frame_d;
            cur_q   <= nxt_scale;
            cks_q   <= cks_en;
            par_q   <= par_mode;
            idx_q   <= EWF_IDX_SOH;
            sum_q   <= '0;
            char_q  <= add_parity(EWF_SOH, par_mode);
          end
        end
        S_SEND: begin
          if (take) begin
            sum_q <= sum_nx;
            if (at_end) begin
              st_q <= S_IDLE;
            end else begin
              idx_q  <= idx_nx;
              char_q <= add_parity(nxt_ch, par_q);
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  assign tx_valid = (st_q == S_SEND);
  assign tx_char  = char_q;
  assign tx_last  = tx_valid && at_end;
  assign tx_scale = cur_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence stall_s;
    tx_valid && !tx_ready;
  endsequence

  sequence frame_go_s;
    start ##1 tx_valid;
  endsequence

  hdr_first_a:
    assert property (frame_go_s |-> tx_char[6:0] == EWF_SOH && idx_q == EWF_IDX_SOH)
      else $error("frame does not open with header");
  addr_range_a:
    assert property (tx_valid && idx_q == EWF_IDX_ADR |->
                     tx_char[6:0] >= EWF_ADR_DEF &&
                     tx_char[6:0] <= (EWF_ZERO | {3'h0, EWF_ADR_MAX}))
      else $error("address character out of range");
  cr_place_a:
    assert property (tx_valid && at_cr |-> tx_char[6:0] == EWF_CR)
      else $error("carriage return misplaced");
  one_bits_a:
    assert property (tx_valid && idx_q >= EWF_IDX_SB1 && idx_q <= EWF_IDX_SB4 |->
                     tx_char[5])
      else $error("status bit five not set");
  cks_sum_a:
    assert property (tx_valid && idx_q == EWF_IDX_CKS |->
                     7'(sum_q + tx_char[6:0]) == 7'h00)
      else $error("checksum does not cancel frame sum");
  even_parity_a:
    assert property (tx_valid && par_q == EWF_PAR_EVEN |-> ^tx_char == 1'b0)
      else $error("even parity broken");
  invalid_flag_a:
    assert property (frame_q[EWF_IDX_SB3][EWF_SB3_OVER] ||
                     frame_q[EWF_IDX_SB3][EWF_SB3_UNDER] |->
                     frame_q[EWF_IDX_SB3][EWF_SB3_INVALID])
      else $error("invalid flag missing on range fault");
  err_tail_a:
    assert property (frame_q[EWF_IDX_W] == EWF_ERR_E |->
                     frame_q[EWF_IDX_W+7] == EWF_SP && frame_q[EWF_IDX_W+8] == EWF_SP)
      else $error("error record tail not spaces");
  hold_char_a:
    assert property (stall_s |=> tx_valid && $stable(tx_char) && $stable(idx_q))
      else $error("character changed while stalled");
  idx_step_a:
    assert property (tx_valid && tx_ready && !at_end |=> tx_valid && idx_q == $past(idx_q) + 5'h01)
      else $error("frame character skipped");

  // the idle cycle between frames is what lets a receiver resync on the header
  sequence last_take_s;
    tx_valid && tx_ready && tx_last;
  endsequence

  frame_gap_a:
    assert property (last_take_s |=> !tx_valid)
      else $error("no idle cycle after frame end");
  scale_hold_a:
    assert property (tx_valid && !(tx_ready && tx_last) |=> $stable(tx_scale))
      else $error("frame interleaved with another scale");
  stay_idle_a:
    assert property (!tx_valid && !(out_en && any_en) |=> !tx_valid)
      else $error("frame started while output disabled");
  unit_code_a:
    assert property (tx_valid && idx_q == EWF_IDX_SB1 |-> tx_char[3:0] <= EWF_UNIT_MAX)
      else $error("reserved unit code sent");

endmodule

// file: verif/ewf_sink.sv
// line driver and remote display model that takes the character stream
module ewf_sink
  import ewf_pkg::*;
#(
  parameter logic [6:0] MY_ADDR = 7'h31
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // test control: stall every other cycle
  input  wire logic       slow,
  // character stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            got,
  // receiver view: own address, weight ignored, tare may be gross
  output logic [2:0]      seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] pos_q;
  logic       mine_q;
  logic       wt_bad_q;
  logic       tare_gross_q;
  logic       rdy_q;

  assign tx_ready = slow ? rdy_q : 1'b1;
  assign got      = tx_valid & tx_ready;
  assign seen     = {mine_q, wt_bad_q, tare_gross_q};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q        <= 5'h00;
      mine_q       <= 1'b0;
      wt_bad_q     <= 1'b0;
      tare_gross_q <= 1'b0;
      rdy_q        <= 1'b0;
    end else begin
      rdy_q <= ~rdy_q;
      if (got) begin
        pos_q <= tx_last ? 5'h00 : pos_q + 5'h01;
        if (pos_q == 5'h01) mine_q <= (tx_char[6:0] == MY_ADDR);
        if (pos_q == 5'h03) tare_gross_q <= &tx_char[2:1];
        if (pos_q == 5'h04) wt_bad_q <= tx_char[0];
      end
    end
  end
endmodule

// file: verif/extended_weight_frame_tx_test.sv
// self-checking bench of the extended weight frame transmitter
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module extended_weight_frame_tx_test
  import ewf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             mclk, arst_n, out_en, cks_en, slow;
  ewf_par_t         par_mode;
  logic [3:0]       scale_en;
  ewf_scale_t [3:0] scl;
  ewf_scale_t       s;
  logic             tx_valid, tx_ready, tx_last, got;
  logic [7:0]       tx_char;
  logic [2:0]       seen;
  logic [1:0]       tx_scale, sc, sc0;
  logic [7:0]       rx[$];
  int               bad_count, checks;

  ewf_tx #(.NSC(4)) ewf_tx_i (.mclk(mclk), .arst_n(arst_n), .out_en(out_en),
    .cks_en(cks_en), .par_mode(par_mode), .scale_en(scale_en), .scale_i(scl),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char), .tx_last(tx_last),
    .tx_scale(tx_scale));
  ewf_sink ewf_sink_i (.mclk(mclk), .arst_n(arst_n), .slow(slow), .tx_valid(tx_valid),
    .tx_char(tx_char), .tx_last(tx_last), .tx_ready(tx_ready), .got(got), .seen(seen));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic par(logic [6:0] c);
    return par_mode == EWF_PAR_EVEN ? ^c : par_mode == EWF_PAR_ODD ? ~^c : 1'b0;
  endfunction

  // one whole frame as the sink took it; a partial frame is possible if entered mid-run
  task automatic get_frame();
    rx.delete();
    for (int k = 0; k < 400; k++) begin
      @(negedge mclk);
      if (got) begin
        if (rx.size() == 0) sc = tx_scale;
        rx.push_back(tx_char);
        if (tx_last) break;
      end
    end
  endtask

  task automatic chk_frame(input logic [6:0] adr, s1, s2, s3, s4, input string w, t);
    logic [6:0] e[$];
    logic [6:0] sum;
    e = {EWF_SOH, adr, s1, s2, s3, s4};
    for (int i = 0; i < 9; i++) e.push_back(7'(w[i]));
    for (int i = 0; i < 8; i++) e.push_back(7'(t[i]));
    e.push_back(EWF_CR);
    sum = 7'h00;
    foreach (e[i]) sum += e[i];
    if (cks_en) e.push_back(-sum);
    `CHK("frame length", e.size(), rx.size())
    foreach (e[i]) `CHK("frame char", {par(e[i]), e[i]}, rx[i])
  endtask

  // output is only sampled between frames, so let the current one drain first
  task automatic pause();
    @(posedge mclk);
    #1 out_en = 1'b0;
    repeat (60) @(posedge mclk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    results();
  end

  initial begin
    {arst_n, out_en, cks_en, slow} = 4'h0;
    par_mode = EWF_PAR_NONE;
    scale_en = 4'h0;
    scl = '0;
    repeat (16) @(posedge mclk);
    `CHK("valid in reset", 1'b0, tx_valid)
    #1 arst_n = 1'b1;
    s = '0;
    s.addr_sel = 4'h3;
    s.unit = 4'h2;
    {s.center_zero, s.motion, s.net_mode, s.expand_ten} = 4'hf;
    s.tare_type = 2'h2;
    s.range = 2'h1;
    {s.print_init, s.below_min} = 2'h3;
    s.app_flags = 6'h21;
    s.negative = 1'b1;
    s.wt_digits = 32'h1234;
    s.wt_dp = 3'h2;
    s.tare_digits = 32'h50;
    s.tare_dp = 3'h1;
    scl[1] = s;
    scale_en = 4'h2;
    {cks_en, slow, out_en} = 3'h7;
    par_mode = EWF_PAR_EVEN;
    get_frame();
    chk_frame(7'h33, 7'h72, 7'h6d, 7'h70, 7'h61, "   -12.34", "     5.0");
    `CHK("scale index", 2'h1, sc)
    `CHK("receiver view", 3'h0, seen)
    pause();
    s = '0;
    s.unit = 4'hc;
    s.over_cap = 1'b1;
    s.err_en = 1'b1;
    s.err_code = 8'h2e;
    scl[1] = s;
    {cks_en, slow, out_en} = 3'h1;
    par_mode = EWF_PAR_ODD;
    get_frame();
    chk_frame(7'h31, 7'h20, 7'h20, 7'h25, 7'h20, "EA0002e  ", "       0");
    `CHK("receiver view", 3'h6, seen)
    pause();
    {s.power_up, s.over_cap, s.under_zero, s.err_other} = 4'hb;
    s.err_code = 8'h2f;
    s.unit = 4'h9;
    s.tare_type = 2'h3;
    scl[1] = s;
    {cks_en, out_en} = 2'h3;
    par_mode = EWF_PAR_NONE;
    get_frame();
    chk_frame(7'h31, 7'h29, 7'h26, 7'h2b, 7'h20, "EU0002f  ", "       0");
    `CHK("receiver view", 3'h7, seen)
    for (int u = 0; u < 16; u++) begin
      @(posedge mclk);
      #1 s.unit = 4'(u);
      scl[1] = s;
      get_frame();
      get_frame();
      `CHK("unit code", (u < 10) ? 8'h20 + 8'(u) : 8'h20, rx[2])
    end
    pause();
    s = '0;
    s.addr_sel = 4'h9;
    s.wt_digits = 32'h250;
    s.tare_digits = 32'h1005;
    s.tare_dp = 3'h3;
    scl[1] = s;
    s.addr_sel = 4'ha;
    scl[2] = s;
    scale_en = 4'h6;
    par_mode = EWF_PAR_EVEN;
    {slow, out_en} = 2'h3;
    get_frame();
    sc0 = sc;
    for (int f = 0; f < 3; f++) begin
      chk_frame(sc == 2'h1 ? 7'h39 : 7'h31, 7'h20, 7'h20, 7'h20, 7'h20,
        "      250", "   1.005");
      `CHK("alternating scale", (f % 2 == 0) ? sc0 : ~sc0 & 2'h3, sc)
      get_frame();
    end
    results();
  end
endmodule
